/* File: core/sgc_regs.sv */
// Global forwarding and host port control registers with their steering logic
// Operation
// - VLAN enable bit turns tag mode on
// - Snoop bit sends IGMP frames to host
// - Scheduling field: strict, 10/1, 5/1, 2/1
// - Sniff bit one: source and destination match
// - Sniff bit zero: either port matches
// - Duplex bit one means half duplex
// - Duplex bit loads strap at reset
// - Pause bit enables host flow control
// - Pause bit loads strap at reset
// - Speed bit: 10 Mbps, strap default
// - Null VID replaced by port VID
// - Low three bits: storm threshold top
// - Period 50 ms fast, 500 ms slow
// - Low threshold byte from next register
// - Multicast disable limits only broadcast frames
`include "sgc_defines.svh"
`default_nettype none
module sgc_regs #(
	parameter int PERIOD_FAST_CYC = `SGC_PERIOD_FAST_MS * `SGC_CLK_KHZ,
	parameter int PERIOD_SLOW_CYC = `SGC_PERIOD_SLOW_MS * `SGC_CLK_KHZ
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Management port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Strap pins
	input wire logic host_port_duplex_strap_i,
	input wire logic host_port_pause_strap_i,
	input wire logic host_port_speed_strap_i,
	// Neighbouring settings
	input wire logic [7:0] storm_rate_low_i,
	input wire logic mcast_storm_disable_i,
	// Mirroring query
	input wire logic sniff_src_match_i,
	input wire logic sniff_dst_match_i,
	output logic mirror_o,
	// Tag query
	input wire logic [11:0] rx_vid_i,
	input wire logic [11:0] port_vid_i,
	output logic [11:0] fwd_vid_o,
	// Egress scheduling
	input wire logic sched_pick_i,
	input wire logic hi_pend_i,
	input wire logic lo_pend_i,
	output logic serve_hi_o,
	output logic serve_lo_o,
	// Storm limiting
	input wire logic storm_block_i,
	input wire logic frame_bcast_i,
	input wire logic frame_mcast_i,
	output logic storm_limit_o,
	output logic [10:0] storm_thresh_o,
	// Mode levels
	output logic vlan_enable_o,
	output logic igmp_snoop_o,
	output logic host_port_half_duplex_o,
	output logic host_port_pause_o,
	output logic host_port_low_speed_select_o,
	output logic [1:0] sched_mode_o
);
	// ****************************************
	// Register storage
	// ****************************************
	sgc_pkg::sgc_reg_t global_forwarding_control; // Register at 0x05
	sgc_pkg::sgc_reg_t host_port_and_storm_control; // Register at 0x06
	wire wr_gfc = reg_wr_i && (reg_addr_i == `SGC_OFS_GFC);
	wire wr_hpsc = reg_wr_i && (reg_addr_i == `SGC_OFS_HPSC);
	wire sgc_pkg::sgc_reg_t hpsc_reset = {`SGC_HPSC_RESERVED_RESET, host_port_duplex_strap_i,
		host_port_pause_strap_i, host_port_speed_strap_i, `SGC_HPSC_LOW_RESET};

	// Writes every bit, reserved ones included; straps caught during reset
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			global_forwarding_control <= `SGC_GFC_RESET;
			host_port_and_storm_control <= hpsc_reset;
		end else begin
			if (wr_gfc) begin
				global_forwarding_control <= reg_wdata_i;
			end
			if (wr_hpsc) begin
				host_port_and_storm_control <= reg_wdata_i;
			end
		end
	end

	// Registered read; unmapped offsets read zero
	wire [7:0] rd_mux = (reg_addr_i == `SGC_OFS_GFC) ? global_forwarding_control
		: (reg_addr_i == `SGC_OFS_HPSC) ? host_port_and_storm_control : 8'h00;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rd_mux;
			end
		end
	end

	// ****************************************
	// Mode levels
	// ****************************************
	assign vlan_enable_o = global_forwarding_control[`SGC_GFC_VLAN_BIT];
	assign igmp_snoop_o = global_forwarding_control[`SGC_GFC_SNOOP_BIT];
	assign sched_mode_o = global_forwarding_control[`SGC_GFC_SCHED_HI:`SGC_GFC_SCHED_LO];
	assign host_port_half_duplex_o = host_port_and_storm_control[`SGC_HPSC_DUPLEX_BIT];
	assign host_port_pause_o = host_port_and_storm_control[`SGC_HPSC_PAUSE_BIT];
	assign host_port_low_speed_select_o = host_port_and_storm_control[`SGC_HPSC_SPEED_BIT];
	wire sniff_and = global_forwarding_control[`SGC_GFC_SNIFF_BIT];
	wire null_vid_en = host_port_and_storm_control[`SGC_HPSC_NULLVID_BIT];

	// ****************************************
	// Mirroring and tag replacement
	// ****************************************
	wire next_mirror = sniff_and ? (sniff_src_match_i && sniff_dst_match_i)
		: (sniff_src_match_i || sniff_dst_match_i);
	wire [11:0] next_fwd_vid = (null_vid_en && rx_vid_i == 12'h000) ? port_vid_i : rx_vid_i;

	// One-cycle registered answers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mirror_o <= 1'b0;
			fwd_vid_o <= 12'h000;
		end else begin
			mirror_o <= next_mirror;
			fwd_vid_o <= next_fwd_vid;
		end
	end

	// ****************************************
	// Egress scheduler
	// ****************************************
	logic [3:0] hi_run; // High frames served since last low, held at ratio once it gets there
	wire [3:0] ratio = (sched_mode_o == `SGC_SCHED_R10) ? `SGC_RATIO_10
		: (sched_mode_o == `SGC_SCHED_R5) ? `SGC_RATIO_5 : `SGC_RATIO_2;
	wire strict = sched_mode_o == `SGC_SCHED_STRICT;
	wire pick_hi = sched_pick_i && hi_pend_i && (strict || !lo_pend_i || hi_run < ratio);
	wire pick_lo = sched_pick_i && lo_pend_i && !pick_hi;
	// A run longer than a newly chosen ratio is pulled back, so the bound holds once the mode settles
	wire [3:0] next_hi_run = pick_lo ? 4'h0 : (hi_run > ratio) ? ratio
		: (pick_hi && hi_run < ratio) ? hi_run + 4'h1 : hi_run;

	// Grants one queue per pick
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			hi_run <= 4'h0;
			serve_hi_o <= 1'b0;
			serve_lo_o <= 1'b0;
		end else begin
			hi_run <= next_hi_run;
			serve_hi_o <= pick_hi;
			serve_lo_o <= pick_lo;
		end
	end

	// ****************************************
	// Storm protection
	// ****************************************
	assign storm_thresh_o = {host_port_and_storm_control[`SGC_HPSC_STORM_HI:0], storm_rate_low_i};
	wire storm_kind = frame_bcast_i || (!mcast_storm_disable_i && frame_mcast_i);
	wire storm_count = storm_block_i && storm_kind;

	sgc_storm_timer #(
		.PERIOD_FAST_CYC(PERIOD_FAST_CYC),
		.PERIOD_SLOW_CYC(PERIOD_SLOW_CYC)
	) u_timer (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.low_speed_i(host_port_low_speed_select_o),
		.thresh_i(storm_thresh_o),
		.block_i(storm_count),
		.limit_o(storm_limit_o),
		.period_tick_o()
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_vlan_follows_write: assert property (wr_gfc |=> vlan_enable_o == $past(reg_wdata_i[7]))
		else $error("vlan enable not loaded");
	a_snoop_follows_write: assert property (wr_gfc |=> igmp_snoop_o == $past(reg_wdata_i[6]))
		else $error("snoop enable not loaded");
	a_strict_never_low: assert property (strict && hi_pend_i && sched_pick_i |=> !serve_lo_o)
		else $error("low served in strict mode");
	a_ratio_bound: assert property (hi_run <= ratio || $changed(sched_mode_o))
		else $error("high run over ratio");
	a_sniff_and_mode: assert property (sniff_and && !(sniff_src_match_i && sniff_dst_match_i)
		&& !wr_gfc |=> !mirror_o)
		else $error("mirror without both matches");
	a_sniff_or_mode: assert property (!sniff_and && (sniff_src_match_i || sniff_dst_match_i)
		&& !wr_gfc |=> mirror_o)
		else $error("mirror missed on one match");
	a_hpsc_write: assert property (wr_hpsc |=> host_port_and_storm_control == $past(reg_wdata_i))
		else $error("host port register not loaded");
	a_null_vid: assert property (null_vid_en && rx_vid_i == 12'h000 && !wr_hpsc
		|=> fwd_vid_o == $past(port_vid_i))
		else $error("null vid not replaced");
	a_thresh_upper: assert property (wr_hpsc |=> storm_thresh_o[10:8] == $past(reg_wdata_i[2:0]))
		else $error("threshold upper bits wrong");
	a_mcast_excluded: assert property (mcast_storm_disable_i && !frame_bcast_i |-> !storm_count)
		else $error("multicast counted while disabled");
endmodule
`default_nettype wire

/* File: core/sgc_defines.svh */
// Offsets, field positions, reset values and timing counts of the global control pair
`ifndef SGC_DEFINES_SVH
`define SGC_DEFINES_SVH

// Register offsets on the management port
`define SGC_OFS_GFC 8'h05
`define SGC_OFS_HPSC 8'h06

// Forwarding control fields
`define SGC_GFC_VLAN_BIT 7
`define SGC_GFC_SNOOP_BIT 6
`define SGC_GFC_SCHED_HI 3
`define SGC_GFC_SCHED_LO 2
`define SGC_GFC_SNIFF_BIT 0
`define SGC_GFC_RESET 8'h00

// Host port and storm fields
`define SGC_HPSC_DUPLEX_BIT 6
`define SGC_HPSC_PAUSE_BIT 5
`define SGC_HPSC_SPEED_BIT 4
`define SGC_HPSC_NULLVID_BIT 3
`define SGC_HPSC_STORM_HI 2
`define SGC_HPSC_RESERVED_RESET 1'h0
`define SGC_HPSC_LOW_RESET 4'h0

// Scheduling codes and high/low ratios
`define SGC_SCHED_STRICT 2'h0
`define SGC_SCHED_R10 2'h1
`define SGC_SCHED_R5 2'h2
`define SGC_RATIO_10 4'ha
`define SGC_RATIO_5 4'h5
`define SGC_RATIO_2 4'h2

// Storm measurement periods
`define SGC_CLK_KHZ 20000
`define SGC_PERIOD_FAST_MS 50
`define SGC_PERIOD_SLOW_MS 500

`endif

/* File: core/sgc_pkg.sv */
// Types shared by the global control pair
`default_nettype none
package sgc_pkg;
	typedef logic [7:0] sgc_reg_t;
	typedef logic [1:0] sgc_sched_t;
	typedef logic [10:0] sgc_thresh_t;
	typedef logic [23:0] sgc_period_t;
	typedef enum logic {SGC_SERVE_IDLE, SGC_SERVE_BUSY} sgc_serve_e;
endpackage
`default_nettype wire

/* File: core/sgc_storm_timer.sv */
// Storm measurement period timer and block counter
`default_nettype none
module sgc_storm_timer #(
	parameter int PERIOD_FAST_CYC = 1000000,
	parameter int PERIOD_SLOW_CYC = 10000000
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic low_speed_i,
	input wire logic [10:0] thresh_i,
	input wire logic block_i,
	// Status
	output logic limit_o,
	output logic period_tick_o
);
	// ****************************************
	// Period timer
	// ****************************************
	sgc_pkg::sgc_period_t period_cnt; // Cycles into current period
	logic [11:0] block_cnt; // Counted 64-byte blocks
	wire sgc_pkg::sgc_period_t period_last = low_speed_i ? sgc_pkg::sgc_period_t'(PERIOD_SLOW_CYC - 1)
		: sgc_pkg::sgc_period_t'(PERIOD_FAST_CYC - 1);
	wire period_end = period_cnt >= period_last;
	wire sgc_pkg::sgc_period_t next_period = period_end ? '0 : period_cnt + 24'h000001;

	// Counts the period and flags its end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			period_cnt <= '0;
			period_tick_o <= 1'b0;
		end else begin
			period_cnt <= next_period;
			period_tick_o <= period_end;
		end
	end

	// ****************************************
	// Block counter against threshold
	// ****************************************
	wire over = block_cnt >= {1'b0, thresh_i};
	wire [11:0] next_block = period_end ? 12'h000 : (block_i && !over) ? block_cnt + 12'h001 : block_cnt;

	// Restarts the count each period, holds once the limit is reached
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			block_cnt <= 12'h000;
			limit_o <= 1'b0;
		end else begin
			block_cnt <= next_block;
			limit_o <= !period_end && (next_block >= {1'b0, thresh_i});
		end
	end
endmodule
`default_nettype wire

/* File: dv/sgc_mac_model.sv */
// Host MAC model streaming 64-byte block strobes toward the switch
`default_nettype none
module sgc_mac_model (
	// Clock and control
	input wire logic ref_clk_i,
	input wire logic run_i,
	input wire logic bcast_i,
	// Block strobe and frame kind
	output logic block_o,
	output logic bcast_o,
	output logic mcast_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wander = 1'b0; // Idle qualifiers toggle, never a stale level
	// One block per cycle while running
	always @(posedge ref_clk_i) begin
		wander <= ~wander;
		block_o <= run_i;
		bcast_o <= run_i ? bcast_i : wander;
		mcast_o <= run_i | wander;
	end
endmodule
`default_nettype wire

/* File: dv/switch_global_control_3_4_bench.sv */
// Self-checking bench for the forwarding and host port control pair
`default_nettype none
module switch_global_control_3_4_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observed signals
	logic clk = 0, rst = 1, wr = 0, rd = 0, ds = 0, ps = 0, ss = 0, md = 0;
	logic src = 0, dst = 0, pick = 0, hp = 0, lp = 0, run = 0, bc = 0;
	logic [7:0] ad = 0, wd = 0, lo = 0, q, d;
	logic [11:0] rx = 0, pv = 0;
	wire logic [7:0] rdat;
	wire logic [11:0] fv;
	wire logic [10:0] th;
	wire logic [1:0] sm;
	wire logic rv, mir, sh, sl, lim, blk, fb, fm, ve, ig, hd, pe, ls;
	int bad_count = 0, checks_done = 0, seed = 93, i, j, n;
	always #25 clk = ~clk;
	sgc_mac_model i_mac (.ref_clk_i(clk), .run_i(run), .bcast_i(bc), .block_o(blk), .bcast_o(fb), .mcast_o(fm));
	// Short storm periods keep the run brief
	sgc_regs #(.PERIOD_FAST_CYC(20), .PERIOD_SLOW_CYC(200)) i_dut (
		.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdat), .reg_rvalid_o(rv), .host_port_duplex_strap_i(ds), .host_port_pause_strap_i(ps),
		.host_port_speed_strap_i(ss), .storm_rate_low_i(lo), .mcast_storm_disable_i(md),
		.sniff_src_match_i(src), .sniff_dst_match_i(dst), .mirror_o(mir), .rx_vid_i(rx), .port_vid_i(pv),
		.fwd_vid_o(fv), .sched_pick_i(pick), .hi_pend_i(hp), .lo_pend_i(lp), .serve_hi_o(sh), .serve_lo_o(sl),
		.storm_block_i(blk), .frame_bcast_i(fb), .frame_mcast_i(fm), .storm_limit_o(lim), .storm_thresh_o(th),
		.vlan_enable_o(ve), .igmp_snoop_o(ig), .host_port_half_duplex_o(hd), .host_port_pause_o(pe),
		.host_port_low_speed_select_o(ls), .sched_mode_o(sm));
	// Compare and count
	task chk(input logic [11:0] s, input logic [11:0] x);
		checks_done++;
		if (s !== x) begin
			bad_count++;
			$display("Error at %0t: saw %h, want %h", $time, s, x);
		end
	endtask
	// Register write, strobe up for one edge
	task wrr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		ad <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Register read, answer one edge after the strobe
	task rdr(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		ad <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdat;
		chk(rv, 1'b1);
	endtask
	// One egress slot
	task pk;
		@(posedge clk);
		pick <= 1'b1;
		@(posedge clk);
		pick <= 1'b0;
		#1;
	endtask
	// High grants per low grant
	function automatic int rat(input int m);
		return m == 1 ? 10 : m == 2 ? 5 : m == 3 ? 2 : 0;
	endfunction
	// Cycles between two falls of the limit flag
	task gap(output int c);
		for (int k = 0; k < 2; k++) begin
			c = 0;
			while (lim !== 1'b1 && c < 500) begin
				@(posedge clk);
				#1 c++;
			end
			while (lim !== 1'b0 && c < 500) begin
				@(posedge clk);
				#1 c++;
			end
		end
	endtask
	// Verdict
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		close_out;
	end
	initial begin
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			rst <= 1'b1;
			{ds, ps, ss} <= 3'($random(seed));
			repeat (3) @(posedge clk);
			rst <= 1'b0;
			rdr(8'h05);
			chk(q, 8'h00);
			rdr(8'h06);
			chk(q, {1'b0, ds, ps, ss, 4'h0});
			chk({hd, pe, ls}, {ds, ps, ss});
		end
		$display("reset test done");
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			lo <= 8'($random(seed));
			wrr(8'h05, d);
			#1 chk({ve, ig, sm}, {d[7:6], d[3:2]});
			rdr(8'h05);
			chk(q, d);
			wrr(8'h06, d);
			#1 chk({hd, pe, ls}, d[6:4]);
			chk(th, {d[2:0], lo});
			rdr(8'h06);
			chk(q, d);
		end
		rdr(8'h07);
		chk(q, 8'h00);
		$display("register test done");
		for (i = 0; i < 8; i++) begin
			wrr(8'h05, {7'h0, i[2]});
			src <= i[1];
			dst <= i[0];
			repeat (2) @(posedge clk);
			#1 chk(mir, i[2] ? i[1] & i[0] : i[1] | i[0]);
			wrr(8'h06, {4'h0, i[1], 3'h0});
			rx <= i[0] ? 12'($random(seed)) | 12'h800 : 12'h0;
			pv <= 12'($random(seed));
			repeat (2) @(posedge clk);
			#1 chk(fv, (i[1] && !i[0]) ? pv : rx);
		end
		$display("mirror and tag test done");
		hp <= 1'b1;
		lp <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wrr(8'h05, 8'(i << 2));
			n = 0;
			for (j = 0; j < 2 * rat(i) + 2; j++) begin
				pk;
				chk(sh ^ sl, 1'b1);
				n += sl;
			end
			chk(n, i ? 2 : 0);
		end
		hp <= 1'b0;
		pk;
		chk({sh, sl}, 2'h1);
		lp <= 1'b0;
		pk;
		chk({sh, sl}, 2'h0);
		$display("scheduler test done");
		lo <= 8'h02;
		run <= 1'b1;
		bc <= 1'b1;
		for (i = 0; i < 2; i++) begin
			wrr(8'h06, 8'(i << 4));
			gap(n);
			chk(n, i ? 200 : 20);
		end
		chk(ls, 1'b1);
		wrr(8'h06, 8'h00);
		bc <= 1'b0;
		md <= 1'b1;
		repeat (60) @(posedge clk);
		#1 chk(lim, 1'b0);
		md <= 1'b0;
		gap(n);
		chk(n, 20);
		$display("storm test done");
		close_out;
	end
endmodule
`default_nettype wire
